// >>> fbf_core.sv
`timescale 1ns/1ns
module fbf_core
    import fbf_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // floating fault checks from the arithmetic unit
    input  wire logic                   fp_chk_valid,
    input  wire logic signed [12:0]     fp_true_exp,
    input  wire logic                   fp_div_chk,
    input  wire logic                   div_zero,
    input  wire logic                   div_too_small,
    input  wire logic                   div_not_fp,
    // floating encoder
    input  wire logic                   enc_valid,
    input  wire logic                   enc_coef_neg,
    input  wire logic                   enc_exp_neg,
    input  wire logic [EXP_W-1:0]       enc_exp_mag,
    input  wire logic [COEF_W-1:0]      enc_coef,
    output logic      [WORD_W-1:0]      enc_word_r,
    // floating decoder
    input  wire logic                   dec_valid,
    input  wire logic [WORD_W-1:0]      dec_word,
    output logic                        dec_neg_r,
    output logic signed [11:0]          dec_true_exp_r,
    output logic      [COEF_W-1:0]      dec_coef_r,
    // checked digits for decimal add and subtract
    output logic                        dig_valid_r,
    output logic      [1:0]             dig_op_r,
    output logic      [3:0]             dig_idx_r,
    output logic      [DIGIT_W-1:0]     dig_val_r,
    output logic                        dig_sign_neg_r,
    // interrupt request
    output logic                        fault_irq
);

    state_e             st_r;
    state_e             st_nxt;
    op_e                op_r;
    logic [1:0]         pos_r;
    logic [3:0]         k_r;
    logic [3:0]         flen_r;
    logic [SWORD_W-1:0] word_r;
    logic [ACC_W-1:0]   acc_r;
    logic [ACC_W-1:0]   acc_nxt;
    logic [NF-1:0]      fault_r;
    logic [NF-1:0]      irq_en_r;
    logic [31:0]        prdata_r;
    logic [31:0]        rd_mux;

    function automatic logic [WORD_W-1:0] fp_encode(input logic neg, input logic eneg,
                                                    input logic [EXP_W-1:0] mag,
                                                    input logic [COEF_W-1:0] coef);
        logic [EXP_W-1:0]  biased;
        logic [WORD_W-1:0] w;
        // minus zero is biased as plus zero
        biased = (eneg && mag != '0) ? BIAS_NEG - mag : BIAS_POS + mag;
        w = {1'b0, biased, coef};
        fp_encode = neg ? ~w : w;
    endfunction

    function automatic logic [DIGIT_W-1:0] legal_digit(input logic [CHAR_W-1:0] ch);
        legal_digit = (ch[DIGIT_W-1:0] > DIGIT_MAX) ? '0 : ch[DIGIT_W-1:0];
    endfunction

    // apb decode
    wire acc_ph   = psel && penable;
    wire setup_ph = psel && !penable;
    wire hit      = paddr == OFF_SENSE || paddr == OFF_IRQ_EN || paddr == OFF_FLEN ||
                    paddr == OFF_WORD || paddr == OFF_CMD || paddr == OFF_ACC_LO ||
                    paddr == OFF_ACC_HI;
    wire wr       = acc_ph && pwrite && hit;
    wire sense_rd = acc_ph && !pwrite && paddr == OFF_SENSE;
    wire busy     = st_r == ST_RUN;
    wire flen_wr  = wr && paddr == OFF_FLEN;
    wire cmd_wr   = wr && paddr == OFF_CMD && !busy;
    wire word_wr  = wr && paddr == OFF_WORD && !busy;
    wire acc_lo_wr = wr && paddr == OFF_ACC_LO;
    wire acc_hi_wr = wr && paddr == OFF_ACC_HI;
    wire op_e     cmd_op = op_e'(pwdata[CMD_OP +: 2]);
    wire cmd_new  = pwdata[CMD_NEW];

    // character stepping: position 0 holds the most significant character
    wire [1:0]        slot     = 2'(CHARS - 1) - pos_r;
    wire [CHAR_W-1:0] cur_char = word_r[slot * CHAR_W +: CHAR_W];
    // lengths above twelve only use the lower twelve characters
    wire [3:0]        eff_len  = (flen_r > FLEN_MAX) ? FLEN_MAX : flen_r;
    wire              in_field = k_r < eff_len;
    wire              step     = busy && in_field;
    wire              is_lsc   = k_r == '0;
    wire              dig_bad  = cur_char[DIGIT_W-1:0] > DIGIT_MAX;
    wire              zone_bad = !is_lsc && cur_char[CHAR_W-1:DIGIT_W] != '0;
    wire              sign_neg = cur_char[CHAR_W-1:DIGIT_W] == ZONE_NEG;
    wire [DIGIT_W-1:0] digit   = legal_digit(cur_char);
    wire              last     = pos_r == '0 || k_r + 4'h1 >= eff_len;

    // fault events
    wire exp_ovf = fp_chk_valid && fp_true_exp > EXP_LIMIT;
    wire exp_unf = fp_chk_valid && fp_true_exp < -EXP_LIMIT;
    wire div_bad = fp_div_chk && (div_zero || div_too_small || div_not_fp);
    wire flen_bad = flen_wr && pwdata[3:0] > FLEN_MAX;
    wire bcd_bad = (step && (dig_bad || zone_bad)) || flen_bad;
    wire [NF-1:0] fault_evt = {bcd_bad, div_bad, exp_unf, exp_ovf};
    // a new event in the sensing cycle survives the clear; bits raised after the read
    // data was latched were never shown, so the sense leaves them set
    wire [NF-1:0] fault_nxt = (sense_rd ? fault_r & ~prdata_r[NF-1:0] : fault_r)
                              | fault_evt;

    // floating decode
    wire [WORD_W-1:0] dec_pos   = dec_word[WORD_W-1] ? ~dec_word : dec_word;
    wire [EXP_W-1:0]  dec_be    = dec_pos[WORD_W-2:COEF_W];
    wire [11:0]       dec_te    = (dec_be >= BIAS_POS) ? {1'b0, dec_be} - {1'b0, BIAS_POS}
                                                       : {1'b0, dec_be} - {1'b0, BIAS_NEG};

    assign rd_mux = (paddr == OFF_SENSE)  ? 32'({busy, 4'h0, fault_r}) :
                    (paddr == OFF_IRQ_EN) ? 32'(irq_en_r) :
                    (paddr == OFF_FLEN)   ? 32'(flen_r) :
                    (paddr == OFF_WORD)   ? 32'(word_r) :
                    (paddr == OFF_CMD)    ? 32'({pos_r, op_r}) :
                    (paddr == OFF_ACC_LO) ? acc_r[LO_W-1:0] :
                    (paddr == OFF_ACC_HI) ? 32'(acc_r[ACC_W-1:LO_W]) : 32'h0;

    assign prdata    = prdata_r;
    assign pready    = 1'b1;
    assign pslverr   = acc_ph && !hit;
    assign fault_irq = |(fault_r & irq_en_r);
    assign st_nxt    = cmd_wr && cmd_op != OP_NONE ? ST_RUN :
                       (busy && (last || !in_field)) ? ST_IDLE : st_r;

    always_comb begin
        acc_nxt = acc_r;
        if (acc_lo_wr) begin
            acc_nxt[LO_W-1:0] = pwdata;
        end
        if (acc_hi_wr) begin
            acc_nxt[ACC_W-1:LO_W] = pwdata[ACC_W-LO_W-1:0];
        end
        // zones never enter the accumulator; the overflow digit stays zero on load
        if (cmd_wr && cmd_new && cmd_op == OP_LOAD) begin
            acc_nxt = '0;
        end
        if (step && op_r == OP_LOAD) begin
            acc_nxt[k_r * DIGIT_W +: DIGIT_W] = digit;
            if (is_lsc) begin
                acc_nxt[ACC_SIGN] = sign_neg;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_r  <= '0;
            irq_en_r <= '0;
            flen_r   <= '0;
            acc_r    <= '0;
            prdata_r <= '0;
        end else begin
            fault_r  <= fault_nxt;
            acc_r    <= acc_nxt;
            if (setup_ph) begin
                prdata_r <= rd_mux;
            end
            if (wr && paddr == OFF_IRQ_EN) begin
                irq_en_r <= pwdata[NF-1:0];
            end
            if (flen_wr) begin
                flen_r <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r   <= ST_IDLE;
            op_r   <= OP_NONE;
            pos_r  <= '0;
            k_r    <= '0;
            word_r <= '0;
        end else begin
            st_r <= st_nxt;
            if (word_wr) begin
                word_r <= pwdata[SWORD_W-1:0];
            end
            if (cmd_wr) begin
                op_r  <= cmd_op;
                pos_r <= pwdata[CMD_POS +: 2];
                k_r   <= cmd_new ? '0 : k_r;
            end else if (step) begin
                pos_r <= pos_r - 2'h1;
                k_r   <= k_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dig_valid_r    <= 1'b0;
            dig_op_r       <= '0;
            dig_idx_r      <= '0;
            dig_val_r      <= '0;
            dig_sign_neg_r <= 1'b0;
        end else begin
            dig_valid_r <= step && (op_r == OP_ADD || op_r == OP_SUB);
            if (step) begin
                dig_op_r  <= op_r;
                dig_idx_r <= k_r;
                dig_val_r <= digit;
                if (is_lsc) begin
                    dig_sign_neg_r <= sign_neg;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enc_word_r     <= '0;
            dec_neg_r      <= 1'b0;
            dec_true_exp_r <= '0;
            dec_coef_r     <= '0;
        end else begin
            if (enc_valid) begin
                enc_word_r <= fp_encode(enc_coef_neg, enc_exp_neg, enc_exp_mag, enc_coef);
            end
            if (dec_valid) begin
                dec_neg_r      <= dec_word[WORD_W-1];
                dec_true_exp_r <= dec_te;
                dec_coef_r     <= dec_pos[COEF_W-1:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    exp_ovf_flag_a: assert property (exp_ovf |=> fault_r[FB_OVF] until sense_rd)
        else $error("overflow fault not held");
    exp_unf_flag_a: assert property (
        fp_chk_valid && fp_true_exp < -EXP_LIMIT |=> fault_r[FB_UNF])
        else $error("underflow fault missing");
    div_fault_a: assert property (fp_div_chk && div_zero |=> fault_r[FB_DIV])
        else $error("divide fault missing");
    div_other_a: assert property (
        fp_div_chk && (div_too_small || div_not_fp) |=> fault_r[FB_DIV])
        else $error("divisor fault missing");
    // only the bits shown in the read data are cleared
    sense_clear_a: assert property (
        sense_rd && fault_evt == '0
        |=> fault_r == ($past(fault_r) & ~$past(prdata_r[NF-1:0])))
        else $error("sense did not clear faults");
    sense_keep_a: assert property (
        sense_rd && fault_evt != '0 |=> (fault_r & $past(fault_evt)) == $past(fault_evt))
        else $error("fault lost in sensing cycle");
    fault_irq_a: assert property (
        exp_ovf && irq_en_r[FB_OVF] && !(wr && paddr == OFF_IRQ_EN) |=> fault_irq)
        else $error("fault did not raise interrupt");
    pos_bias_a: assert property (
        enc_valid && !enc_exp_neg && !enc_coef_neg
        |=> enc_word_r[WORD_W-2:COEF_W] == BIAS_POS + $past(enc_exp_mag))
        else $error("positive exponent misbiased");
    neg_zero_a: assert property (
        enc_valid && enc_exp_neg && enc_exp_mag == '0 && !enc_coef_neg
        |=> enc_word_r[WORD_W-2:COEF_W] == BIAS_POS)
        else $error("minus zero exponent misbiased");
    neg_compl_a: assert property (
        enc_valid && enc_coef_neg
        |=> enc_word_r[WORD_W-1] && enc_word_r[COEF_W-1:0] == ~$past(enc_coef))
        else $error("negative word not complemented");
    decode_exp_a: assert property (
        dec_valid && !dec_word[WORD_W-1] && dec_word[WORD_W-2:COEF_W] < BIAS_POS
        |=> dec_true_exp_r == $signed(12'($past(dec_be)) - 12'(BIAS_NEG)))
        else $error("decoded exponent wrong");
    sign_pick_a: assert property (
        step && is_lsc |=> dig_sign_neg_r == $past(cur_char[CHAR_W-1:DIGIT_W] == ZONE_NEG))
        else $error("field sign misdecoded");
    digit_pass_a: assert property (
        step && !dig_bad |=> dig_val_r == $past(cur_char[DIGIT_W-1:0]))
        else $error("legal digit altered");
    bad_digit_a: assert property (step && dig_bad |=> fault_r[FB_BCD])
        else $error("illegal digit not flagged");
    zone_fault_a: assert property (step && zone_bad |=> fault_r[FB_BCD])
        else $error("stray zone not flagged");
    acc_sign_a: assert property (
        step && is_lsc && op_r == OP_LOAD && !acc_hi_wr |=> acc_r[ACC_SIGN] == $past(sign_neg))
        else $error("accumulator sign wrong");
    field_len_a: assert property (step |-> k_r < FLEN_MAX)
        else $error("character count past field");
    flen_fault_a: assert property (flen_bad |=> fault_r[FB_BCD] && flen_r > FLEN_MAX)
        else $error("field length fault missing");
    load_zero_a: assert property (
        step && op_r == OP_LOAD && dig_bad && !acc_lo_wr && !acc_hi_wr
        |=> acc_r[$past(k_r) * DIGIT_W +: DIGIT_W] == '0)
        else $error("illegal digit not replaced by zero");
    bcd_sticky_a: assert property (fault_r[FB_BCD] && !sense_rd |=> fault_r[FB_BCD])
        else $error("decimal fault dropped");

    load_run_c: cover property (cmd_wr && cmd_op == OP_LOAD ##1 busy [*4] ##1 !busy);
    sense_hit_c: cover property (fault_r[FB_BCD] ##1 sense_rd);
    irq_c: cover property (div_bad && irq_en_r[FB_DIV] ##1 fault_irq);
    neg_field_c: cover property (step && is_lsc && sign_neg);
    zone_skip_c: cover property (step && zone_bad ##1 step);
endmodule

// >>> fbf_pkg.sv
package fbf_pkg;
// What this block does
// - exponent above +1777 octal, below -1777 octal, or bad divisor raises a fault
// - fault flags are read by the sense access, which clears them
// - fault flags can drive the interrupt request
// - exponent bias is 2000 octal when zero or above, 1777 octal when negative
// - a minus zero exponent takes the 2000 octal bias
// - a negative value is the one's complement of the whole word
// - decode subtracts 2000 octal if biased exponent is at least that, else 1777
// - a 24-bit word is four 6-bit characters, digit low, zone high
// - sign is negative only for zone bits 1 then 0
// - digits 0 to 9 are plain binary 0000 to 1001
// - digit codes 1010 to 1111 raise the decimal fault
// - nonzero zone outside the least significant character faults, operation continues
// - one sign per field, taken from the least significant character
// - most significant character sits at the earlier storage position
// - decimal accumulator is 53 bits: twelve digits, overflow digit, sign bit, no zones
// - 4-bit field length sets characters processed; 1 to 12 legal
// - on load, add and subtract a digit above nine is used as zero
// - setting field length above twelve raises the decimal fault
// - decimal fault stays set until sensed; the sense clears it

    // register byte offsets
    localparam logic [7:0] OFF_SENSE  = 8'h00;
    localparam logic [7:0] OFF_IRQ_EN = 8'h04;
    localparam logic [7:0] OFF_FLEN   = 8'h08;
    localparam logic [7:0] OFF_WORD   = 8'h0c;
    localparam logic [7:0] OFF_CMD    = 8'h10;
    localparam logic [7:0] OFF_ACC_LO = 8'h14;
    localparam logic [7:0] OFF_ACC_HI = 8'h18;

    // fault bits in sense and enable registers
    localparam int NF       = 4;
    localparam int FB_OVF   = 0;
    localparam int FB_UNF   = 1;
    localparam int FB_DIV   = 2;
    localparam int FB_BCD   = 3;
    localparam int SB_BUSY  = 8;

    // floating format
    localparam int EXP_W    = 11;
    localparam int COEF_W   = 36;
    localparam int WORD_W   = 48;
    localparam logic [EXP_W-1:0] BIAS_POS = 11'h400;
    localparam logic [EXP_W-1:0] BIAS_NEG = 11'h3ff;
    localparam logic signed [12:0] EXP_LIMIT = 13'sh03ff;

    // decimal format
    localparam int CHAR_W   = 6;
    localparam int CHARS    = 4;
    localparam int SWORD_W  = 24;
    localparam int DIGIT_W  = 4;
    localparam int ACC_W    = 53;
    localparam int ACC_SIGN = 52;
    localparam int LO_W     = 32;
    localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
    localparam logic [1:0]         ZONE_NEG  = 2'h2;
    localparam logic [3:0]         FLEN_MAX  = 4'hc;

    // command register fields
    localparam int CMD_OP   = 0;
    localparam int CMD_POS  = 2;
    localparam int CMD_NEW  = 4;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_LOAD = 2'b01,
        OP_ADD  = 2'b10,
        OP_SUB  = 2'b11
    } op_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } state_e;
endpackage

// >>> fbf_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module tb
    import fbf_pkg::*;
;
    logic                clk, rstn, psel, penable, pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, q;
    logic                pready, pslverr, last_err;
    logic                fp_chk_valid, fp_div_chk, div_zero, div_too_small, div_not_fp;
    logic signed [12:0]  fp_true_exp;
    logic                enc_valid, enc_coef_neg, enc_exp_neg, dec_valid, dec_neg_r;
    logic [EXP_W-1:0]    enc_exp_mag;
    logic [COEF_W-1:0]   enc_coef, dec_coef_r;
    logic [WORD_W-1:0]   enc_word_r, dec_word;
    logic signed [11:0]  dec_true_exp_r;
    logic                dig_valid_r, dig_sign_neg_r, fault_irq;
    logic [1:0]          dig_op_r;
    logic [3:0]          dig_idx_r, dig_val_r, faults;
    logic [10:0]         digq[$];
    int                  n_fail, tests_run;
    localparam logic [COEF_W-1:0] HALF = 36'h800000000;

    fbf_core dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fp_chk_valid(fp_chk_valid), .fp_true_exp(fp_true_exp), .fp_div_chk(fp_div_chk),
        .div_zero(div_zero), .div_too_small(div_too_small), .div_not_fp(div_not_fp),
        .enc_valid(enc_valid), .enc_coef_neg(enc_coef_neg), .enc_exp_neg(enc_exp_neg),
        .enc_exp_mag(enc_exp_mag), .enc_coef(enc_coef), .enc_word_r(enc_word_r),
        .dec_valid(dec_valid), .dec_word(dec_word), .dec_neg_r(dec_neg_r),
        .dec_true_exp_r(dec_true_exp_r), .dec_coef_r(dec_coef_r), .dig_valid_r(dig_valid_r),
        .dig_op_r(dig_op_r), .dig_idx_r(dig_idx_r), .dig_val_r(dig_val_r),
        .dig_sign_neg_r(dig_sign_neg_r), .fault_irq(fault_irq));

    always #5 clk = ~clk;
    // registered outputs read before this edge's updates land
    always @(posedge clk) if (dig_valid_r === 1'b1)
        digq.push_back({dig_op_r, dig_idx_r, dig_val_r, dig_sign_neg_r});

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // sense reads clear faults, so collect them while polling busy
    task automatic wait_idle();
        do begin
            apb(1'b0, OFF_SENSE, 32'h0);
            faults |= q[3:0];
        end while (q[SB_BUSY] !== 1'b0);
    endtask

    task automatic fp_ev(input int kind, input logic signed [12:0] e);
        @(posedge clk);
        fp_chk_valid <= (kind == 0); fp_true_exp <= e; fp_div_chk <= (kind != 0);
        div_zero <= (kind == 1); div_too_small <= (kind == 2); div_not_fp <= (kind == 3);
        @(posedge clk);
        fp_chk_valid <= 1'b0; fp_div_chk <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic test_fp_faults();
        fp_ev(0, 13'sd1023); apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h0)
        fp_ev(0, 13'sd1024); apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h1)
        apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h0)
        fp_ev(0, -13'sd1023); apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h0)
        fp_ev(0, -13'sd1024); apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h2)
        for (int k = 1; k <= 4; k++) begin
            fp_ev(k, 13'sd0);
            apb(0, OFF_SENSE, 0);
            `CHK(q[3:0], (k < 4) ? 4'h4 : 4'h0)
        end
    endtask

    // overflow lands on the setup edge of a sense read, after its data was latched
    task automatic test_sense_race();
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= 1'b0; paddr <= OFF_SENSE;
        fp_chk_valid <= 1'b1; fp_true_exp <= 13'sd1024;
        @(posedge clk);
        penable <= 1'b1; fp_chk_valid <= 1'b0;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        `CHK(prdata[3:0], 4'h0)
        psel <= 1'b0; penable <= 1'b0;
        apb(0, OFF_SENSE, 0); `CHK(q[3:0], 4'h1)
    endtask

    task automatic test_irq();
        apb(1, OFF_IRQ_EN, 32'h1);
        fp_ev(0, -13'sd1024); `CHK(fault_irq, 1'b0)
        apb(0, OFF_SENSE, 0);
        fp_ev(0, 13'sd1024); `CHK(fault_irq, 1'b1)
        apb(0, OFF_SENSE, 0);
        @(posedge clk); `CHK(fault_irq, 1'b0)
    endtask

    task automatic enc(input logic cn, en, input logic [10:0] m, input logic [47:0] exp_w);
        @(posedge clk);
        enc_valid <= 1'b1; enc_coef_neg <= cn; enc_exp_neg <= en;
        enc_exp_mag <= m; enc_coef <= HALF;
        @(posedge clk);
        enc_valid <= 1'b0;
        @(posedge clk); `CHK(enc_word_r, exp_w)
    endtask

    task automatic dec(input logic [47:0] w, input logic n, input logic signed [11:0] e);
        @(posedge clk);
        dec_valid <= 1'b1; dec_word <= w;
        @(posedge clk);
        dec_valid <= 1'b0;
        @(posedge clk);
        `CHK({dec_neg_r, dec_true_exp_r, dec_coef_r}, {n, e, HALF})
    endtask

    task automatic test_float_format();
        enc(0, 0, 11'h3, {1'b0, BIAS_POS + 11'h3, HALF});
        enc(1, 0, 11'h3, ~{1'b0, BIAS_POS + 11'h3, HALF});
        enc(0, 1, 11'h0, {1'b0, BIAS_POS, HALF});
        enc(0, 1, 11'h3, {1'b0, BIAS_NEG - 11'h3, HALF});
        dec({1'b0, BIAS_NEG - 11'h3, HALF}, 1'b0, -12'sd3);
        dec(~{1'b0, BIAS_POS + 11'h3, HALF}, 1'b1, 12'sd3);
        dec({1'b0, BIAS_POS, HALF}, 1'b0, 12'sd0);
    endtask

    task automatic test_load();
        apb(1, OFF_ACC_LO, 32'hffffffff);
        apb(1, OFF_FLEN, 32'hd);
        apb(0, OFF_SENSE, 0); `CHK(q[FB_BCD], 1'b1)
        apb(0, OFF_FLEN, 0); `CHK(q[3:0], 4'hd)
        apb(1, OFF_FLEN, 32'h2);
        apb(0, OFF_SENSE, 0); `CHK(q[FB_BCD], 1'b0)
        // least significant char at pos3 carries zone 10, pos2 holds 8
        apb(1, OFF_WORD, 32'h229);
        faults = 4'h0;
        apb(1, OFF_CMD, 32'h1d);
        wait_idle(); `CHK(faults, 4'h0)
        apb(0, OFF_ACC_LO, 0); `CHK(q, 32'h89)
        apb(0, OFF_ACC_HI, 0); `CHK(q, 32'h00100000)
        apb(0, 8'h40, 0); `CHK({last_err, q}, {1'b1, 32'h0})
    endtask

    task automatic test_add();
        apb(1, OFF_FLEN, 32'h3);
        apb(1, OFF_WORD, 32'h754a);
        faults = 4'h0;
        digq.delete();
        apb(1, OFF_CMD, 32'h1e);
        wait_idle(); `CHK(faults[FB_BCD], 1'b1)
        `CHK(digq.size(), 3)
        `CHK(digq[0], {2'h2, 4'h0, 4'h0, 1'b0})
        `CHK(digq[1], {2'h2, 4'h1, 4'h5, 1'b0})
        `CHK(digq[2], {2'h2, 4'h2, 4'h7, 1'b0})
    endtask

    task automatic test_sub_signs();
        apb(1, OFF_FLEN, 32'h1);
        for (int z = 0; z < 4; z++) begin
            // pos2 is illegal but lies past the field length
            apb(1, OFF_WORD, 32'hfc0 | {z[1:0], 4'h3});
            faults = 4'h0;
            digq.delete();
            apb(1, OFF_CMD, 32'h1f);
            wait_idle(); `CHK(faults, 4'h0)
            `CHK(digq.size(), 1)
            `CHK(digq[0], {2'h3, 4'h0, 4'h3, z == 2})
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        fp_chk_valid = 0; fp_true_exp = 0; fp_div_chk = 0; div_zero = 0;
        div_too_small = 0; div_not_fp = 0; enc_valid = 0; enc_coef_neg = 0;
        enc_exp_neg = 0; enc_exp_mag = 0; enc_coef = 0; dec_valid = 0; dec_word = 0;
        n_fail = 0; tests_run = 0; faults = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        test_fp_faults();
        test_sense_race();
        test_irq();
        test_float_format();
        test_load();
        test_add();
        test_sub_signs();
        stop_test();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule
